// ---- dph_codec.sv ----
/*
 * Diphase / manchester serial codec: word transmitter and word receiver.
 * Assumes one system clock, an async active-low reset and a synchronous clear;
 * the received line comes from outside and is synchronised here.
 */
`timescale 1ns/10ps
module dph_codec import dph_pkg::*; #(
	parameter int CELL_C = CELL_CYC,
	parameter int TXP_C = TXPULSE_CYC,
	parameter int RXP_C = RXPULSE_CYC,
	parameter int REC_C = CLKREC_CYC,
	parameter int IDLE_C = IDLE_CYC,
	parameter int W = WORD_BITS,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clear,
	input wire logic manchester_mode,
	input wire logic [W-1:0] tx_word,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_line,
	input wire logic rx_line,
	output logic [W-1:0] rx_word,
	output logic rx_word_valid,
	output logic rx_clock,
	output logic rx_data_pulse
);
	localparam int HALF_C = CELL_C / 2;

	logic [W-1:0] f_data, shift_r, rx_shift_r;
	logic f_valid, f_ready, mode_r, bitclk_r, bitclk_q_r, line_r, cur_bit;
	logic active, cell_end, last_bit, rise_trigger_enable, fall_trigger_enable;
	logic line_s1_r, line_s2_r, line_q_r, data_r, primed_r, rx_bit, rx_stale;
	logic trans, rec_clk;
	logic [15:0] cell_cnt_r, idle_cnt_r;
	logic [7:0] idx_r, rx_cnt_r;
	logic ps_trig [NPS];
	logic ps_start [NPS];
	logic ps_act_r [NPS];
	logic [15:0] ps_cnt_r [NPS];
	dph_tx_state_t state_r, state_nxt;

	function automatic logic [15:0] ps_len(input int i);
		case (i)
			PS_TX: ps_len = 16'(TXP_C);
			PS_RXT: ps_len = 16'(RXP_C);
			default: ps_len = 16'(REC_C);
		endcase
	endfunction : ps_len

	////////////////////////////////////////////////////////////////////////
	// word buffer ahead of the serialiser
	dph_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.clear(clear),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_word),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	////////////////////////////////////////////////////////////////////////
	// transmit sequencing
	assign active = state_r != DPH_IDLE;
	assign cell_end = active && cell_cnt_r == 16'(CELL_C - 1);
	assign last_bit = idx_r == 8'(W - 1);
	assign cur_bit = (state_r == DPH_PRE) ? 1'b1 : (state_r == DPH_BITS) ? shift_r[0] : 1'b0;
	// reload only between words, so a stalled fifo really fills
	assign f_ready = !clear && (state_r == DPH_IDLE || (cell_end && state_r == DPH_BITS && last_bit)); // RULE8

	// next state; manchester words carry a leading one as lock preamble
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DPH_IDLE: begin
				if (f_valid && f_ready)
					state_nxt = manchester_mode ? DPH_PRE : DPH_BITS;
			end
			DPH_PRE: begin
				if (cell_end)
					state_nxt = DPH_BITS;
			end
			DPH_BITS: begin
				if (cell_end && last_bit)
					state_nxt = !f_valid ? DPH_CLOSE : manchester_mode ? DPH_PRE : DPH_BITS;
			end
			DPH_CLOSE: begin
				if (cell_end && idx_r == 8'(GAP_CELLS - 1))
					state_nxt = DPH_IDLE;
			end
			default: state_nxt = DPH_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			state_r <= DPH_IDLE;
		else if (clear)
			state_r <= DPH_IDLE; // RULE16
		else
			state_r <= state_nxt;
	end

	// cell counter, bit index and parallel-load shift register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cell_cnt_r <= '0;
			idx_r <= '0;
			shift_r <= '0;
			mode_r <= 1'b0;
		end else if (clear) begin
			cell_cnt_r <= '0; // RULE16
			idx_r <= '0;
			shift_r <= '0;
			mode_r <= 1'b0;
		end else if (f_valid && f_ready) begin
			shift_r <= f_data; // RULE8
			mode_r <= manchester_mode;
			idx_r <= '0;
			cell_cnt_r <= '0;
		end else if (active) begin
			cell_cnt_r <= cell_end ? 16'h0000 : cell_cnt_r + 16'h0001;
			if (cell_end) begin
				if (state_r == DPH_BITS)
					shift_r <= {1'b0, shift_r[W-1:1]}; // RULE8
				idx_r <= (state_r == DPH_PRE || (state_r == DPH_BITS && last_bit)) ?
					8'h00 : idx_r + 8'h01;
			end
		end
	end

	// bit clock: falls at each boundary, rises mid-cell; rests high so the
	// first cell after idle always opens with a boundary edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bitclk_r <= 1'b1;
			bitclk_q_r <= 1'b1;
		end else if (clear) begin
			bitclk_r <= 1'b1; // RULE16
			bitclk_q_r <= 1'b1;
		end else begin
			bitclk_q_r <= bitclk_r;
			if (active && cell_cnt_r == 16'h0000 && !(state_r == DPH_CLOSE && idx_r != 8'h00))
				bitclk_r <= 1'b0; // RULE2
			else if (active && cell_cnt_r == 16'(HALF_C))
				bitclk_r <= 1'b1;
		end
	end

	// doubler: boundary always triggers, mid-cell only for a one
	assign rise_trigger_enable = cur_bit; // RULE6
	assign fall_trigger_enable = 1'b1;
	assign ps_trig[PS_TX] = !mode_r &&
		dph_trig(bitclk_q_r, bitclk_r, rise_trigger_enable, fall_trigger_enable); // RULE5 RULE4

	// line flip-flop: toggled per trigger in diphase, driven per half in manchester
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			line_r <= 1'b0;
		else if (clear)
			line_r <= 1'b0; // RULE16
		else if (!mode_r) begin
			if (ps_start[PS_TX])
				line_r <= !line_r; // RULE7 RULE1
		end else if (active && cell_cnt_r == 16'h0000)
			line_r <= (state_r == DPH_CLOSE) ? 1'b0 : !cur_bit; // RULE3
		else if (active && cell_cnt_r == 16'(HALF_C))
			line_r <= cur_bit; // RULE3
	end
	assign tx_line = line_r;

	////////////////////////////////////////////////////////////////////////
	// pulse generators; a trigger during a pulse is dropped, clear kills it
	for (genvar g = 0; g < NPS; g++) begin : g_ps
		assign ps_start[g] = ps_trig[g] && !ps_act_r[g] && !clear; // RULE13 RULE14
		always_ff @(posedge clock or negedge nrst) begin
			if (!nrst) begin
				ps_act_r[g] <= 1'b0;
				ps_cnt_r[g] <= '0;
			end else if (clear) begin
				ps_act_r[g] <= 1'b0; // RULE14
				ps_cnt_r[g] <= '0;
			end else if (ps_start[g]) begin
				ps_act_r[g] <= 1'b1;
				ps_cnt_r[g] <= ps_len(g) - 16'h0001; // RULE15
			end else if (ps_act_r[g]) begin
				if (ps_cnt_r[g] == 16'h0000)
					ps_act_r[g] <= 1'b0;
				else
					ps_cnt_r[g] <= ps_cnt_r[g] - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive front end: two-stage sync, then edge detect on both edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			line_s1_r <= 1'b0;
			line_s2_r <= 1'b0;
			line_q_r <= 1'b0;
		end else begin
			line_s1_r <= rx_line; // RULE15
			line_s2_r <= line_s1_r;
			line_q_r <= line_s2_r;
		end
	end

	assign ps_trig[PS_RXT] = dph_trig(line_q_r, line_s2_r, 1'b1, 1'b1); // RULE9 RULE4
	assign trans = ps_start[PS_RXT];
	// recovery pulse spans 3/4 cell, so mid-cell edges fall inside it
	assign ps_trig[PS_REC] = trans; // RULE10
	assign rec_clk = ps_start[PS_REC];

	// data flip-flop: any transition sets, recovered clock clears (clock wins)
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			data_r <= 1'b0;
		else if (clear || rec_clk)
			data_r <= 1'b0; // RULE11
		else if (trans)
			data_r <= 1'b1; // RULE11
	end
	assign rx_data_pulse = data_r;
	assign rx_clock = ps_act_r[PS_REC];

	// manchester locks on mid-cell edges: the new level is the bit
	assign rx_bit = manchester_mode ? line_s2_r : data_r; // RULE3

	// silence for two cells ends a frame
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			idle_cnt_r <= '0;
		else if (clear || trans)
			idle_cnt_r <= '0;
		else if (idle_cnt_r != 16'(IDLE_C))
			idle_cnt_r <= idle_cnt_r + 16'h0001;
	end
	assign rx_stale = idle_cnt_r == 16'(IDLE_C);

	// first clock of a frame only primes; later ones shift the previous cell in diphase, the current level in manchester
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			primed_r <= 1'b0;
			rx_cnt_r <= '0;
			rx_shift_r <= '0;
			rx_word <= '0;
			rx_word_valid <= 1'b0;
		end else if (clear) begin
			primed_r <= 1'b0; // RULE16
			rx_cnt_r <= '0;
			rx_shift_r <= '0;
			rx_word <= '0;
			rx_word_valid <= 1'b0;
		end else begin
			rx_word_valid <= 1'b0;
			if (rec_clk) begin
				if (!primed_r)
					primed_r <= 1'b1;
				else begin
					rx_shift_r <= {rx_bit, rx_shift_r[W-1:1]}; // RULE12
					if (rx_cnt_r == 8'(W - 1)) begin
						rx_word <= {rx_bit, rx_shift_r[W-1:1]}; // RULE12
						rx_word_valid <= 1'b1;
						rx_cnt_r <= '0;
						primed_r <= !manchester_mode;
					end else
						rx_cnt_r <= rx_cnt_r + 8'h01;
				end
			end else if (rx_stale) begin
				primed_r <= 1'b0;
				rx_cnt_r <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [1:0] trig_cnt_r;
	logic line_prev_r;
	logic [15:0] quiet_cnt_r, rec_gap_r;

	// helpers: triggers per cell, cycles without a line edge, gap between clocks;
	// the quiet count watches the pin itself so a lost toggle cannot hide
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			trig_cnt_r <= '0;
			line_prev_r <= 1'b0;
			quiet_cnt_r <= '0;
			rec_gap_r <= 16'hffff;
		end else begin
			line_prev_r <= tx_line;
			if (cell_cnt_r == 16'h0000)
				trig_cnt_r <= '0;
			else if (ps_start[PS_TX])
				trig_cnt_r <= trig_cnt_r + 2'h1;
			if (tx_line != line_prev_r || !(state_r inside {DPH_PRE, DPH_BITS}))
				quiet_cnt_r <= '0;
			else if (quiet_cnt_r != 16'hffff)
				quiet_cnt_r <= quiet_cnt_r + 16'h0001;
			// a clear ends the pulse, so the next clock may legally come early
			if (rec_clk)
				rec_gap_r <= '0;
			else if (clear)
				rec_gap_r <= 16'hffff;
			else if (rec_gap_r != 16'hffff)
				rec_gap_r <= rec_gap_r + 16'h0001;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_one_two_trig: assert property (cell_cnt_r == 16'(CELL_C - 1) && state_r == DPH_BITS // RULE1
		&& !mode_r && !clear && !$past(clear) |-> trig_cnt_r == {1'b0, cur_bit} + 2'h1)
		else $error("diphase cell has wrong trigger count");
	a_cell_has_edge: assert property (!mode_r |-> quiet_cnt_r <= 16'(CELL_C)) // RULE2
		else $error("cell without a line transition");
	a_manch_mid_dir: assert property (mode_r && state_r == DPH_BITS && !clear // RULE3
		&& cell_cnt_r == 16'(HALF_C + 1) && !$past(clear) |-> line_r == cur_bit && $past(line_r) != cur_bit)
		else $error("manchester mid-cell transition has wrong direction");
	a_mid_needs_one: assert property (ps_trig[PS_TX] && bitclk_r |-> cur_bit) // RULE6
		else $error("mid-cell trigger for a zero");
	a_tx_line_toggle: assert property (ps_start[PS_TX] |=> tx_line != $past(tx_line)) // RULE7
		else $error("trigger did not toggle the line");
	a_no_retrig: assert property (ps_act_r[PS_REC] && ps_cnt_r[PS_REC] != 16'h0000 && ps_trig[PS_REC] // RULE13
		&& !clear |=> ps_act_r[PS_REC] && ps_cnt_r[PS_REC] == $past(ps_cnt_r[PS_REC]) - 16'h0001)
		else $error("recovery pulse retriggered");
	a_clear_ends: assert property (clear |=> !ps_act_r[PS_TX] && !ps_act_r[PS_RXT] // RULE14
		&& !ps_act_r[PS_REC] && !tx_line && rx_cnt_r == 8'h00)
		else $error("clear did not end pulses");
	a_rec_gap_long: assert property (rec_clk |-> rec_gap_r > 16'(HALF_C)) // RULE10
		else $error("two recovered clocks in one cell");
	a_rx_double: assert property (line_s2_r != line_q_r && !ps_act_r[PS_RXT] && !clear |-> trans) // RULE9
		else $error("line transition without a pulse");
	a_data_shift: assert property (rec_clk && primed_r && !manchester_mode && !clear // RULE11
		|=> rx_shift_r[W-1] == $past(data_r))
		else $error("received bit is not the data flip-flop");
	a_word_ten: assert property (rx_word_valid |-> $past(rx_cnt_r) == 8'(W - 1) && $past(rec_clk)) // RULE12
		else $error("word presented after wrong bit count");
	a_first_boundary: assert property ($past(state_r) == DPH_IDLE && active && !clear // RULE16
		|=> !bitclk_r && $past(bitclk_r))
		else $error("first cell does not open with a boundary");

	c_one_cell: cover property (cell_end && trig_cnt_r == 2'h2);
	c_word_rx: cover property (rx_word_valid && !manchester_mode);
	c_manch_word: cover property (rx_word_valid && manchester_mode);
	c_fifo_full: cover property (!tx_ready && active);
endmodule : dph_codec

// ---- dph_pkg.sv ----
/*
 * Shared constants, state type and the edge trigger decode for the diphase codec.
 * Assumes a single 250 MHz system clock; all times are converted to cycles here.
 */
// Notes on behaviour
// (RULE1) a one has boundary and mid-cell transitions, a zero only the boundary
// (RULE2) every bit cell on the line carries at least one transition
// (RULE3) manchester mode carries the bit in the mid-cell transition direction
// (RULE4) edge detector fires once per rise and fall, each gated by its enable
// (RULE5) transmitter doubles bit clock: one trigger per zero, two per one
// (RULE6) data bit drives the rise trigger enable directly, without extra gating
// (RULE7) each transmit trigger pulse toggles the line flip-flop driving the line
// (RULE8) ten-bit word loads in parallel, shifts out, ten-cell counter paces reload
// (RULE9) receiver enables both edges, giving a pulse for every line transition
// (RULE10) clock recovery pulse is longer than half a cell, non-retriggerable
// (RULE11) data flip-flop set by transition pulses, cleared by recovered clock
// (RULE12) recovered bits shift into a ten-bit register, word presented in parallel
// (RULE13) a trigger arriving during an active pulse is ignored
// (RULE14) clear blocks new triggers and ends running pulses at once
// (RULE15) pulse lengths are cycle counts; line input synchronised before edge detect
// (RULE16) after reset or clear all state is zero except the bit clock (high) and, after clear, fifo ready; first cell opens with boundary
//          (clear does not reset the receive line synchronisers line_s1_r, line_s2_r and line_q_r; they keep sampling rx_line)
package dph_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CELL_NS = 200;
	localparam int CELL_CYC = (CELL_NS * 1000) / CLK_PERIOD_PS;
	localparam int TXPULSE_NS = 8;
	localparam int TXPULSE_CYC = (TXPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RXPULSE_NS = 8;
	localparam int RXPULSE_CYC = (RXPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLKREC_NS = 150;
	localparam int CLKREC_CYC = (CLKREC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int IDLE_NS = 400;
	localparam int IDLE_CYC = (IDLE_NS * 1000) / CLK_PERIOD_PS;
	localparam int WORD_BITS = 10;
	localparam int FIFO_DEPTH = 4;
	localparam int GAP_CELLS = 3;
	localparam int NPS = 3;
	localparam int PS_TX = 0;
	localparam int PS_RXT = 1;
	localparam int PS_REC = 2;

	typedef enum logic [1:0] {
		DPH_IDLE = 2'b00,
		DPH_PRE = 2'b01,
		DPH_BITS = 2'b11,
		DPH_CLOSE = 2'b10
	} dph_tx_state_t;

	// one trigger per enabled edge of a level
	function automatic logic dph_trig(input logic prev, input logic cur,
		input logic rise_en, input logic fall_en);
		dph_trig = (rise_en && !prev && cur) || (fall_en && prev && !cur);
	endfunction : dph_trig
endpackage : dph_pkg

// ---- dph_fifo.sv ----
/*
 * Small word FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes the same clock and reset as its user; clear empties it.
 */
`timescale 1ns/10ps
module dph_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, rd_r;
	logic [AW:0] count_r, count_nxt;
	logic push, pop;

	// ready is registered so the source sees back-pressure straight from a flop
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = count_r != '0;
	assign out_data = mem_r[rd_r];
	assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);

	////////////////////////////////////////////////////////////////////////
	// pointers and fill level
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
			count_r <= '0;
			in_ready <= 1'b0;
		end else if (clear) begin
			wr_r <= '0;
			rd_r <= '0;
			count_r <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			count_r <= count_nxt;
			in_ready <= count_nxt != (AW + 1)'(DEPTH);
		end
	end

	// storage, no reset needed on data
	always_ff @(posedge clock) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end
endmodule : dph_fifo

// ---- dph_far_end.sv ----
/*
 * Remote end of the serial line: a diphase/manchester sender and a behavioural line decoder.
 * Assumes the codec's system clock; drives rx_line just after rising edges, samples on falling.
 */
`timescale 1ns/10ps
module dph_far_end #(
	parameter int CELL_C = 8,
	parameter int W = 10
) (
	input wire logic clock,
	input wire logic tx_line,
	output logic rx_line
);
	localparam int HALF_C = CELL_C / 2;
	logic [W-1:0] got [8];
	int bad;

	////////////////////////////////////////////////////////////////////////////////
	// sender: a driven line, so it holds its last level between frames
	initial begin
		rx_line = 1'b0;
		bad = 0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic send(input logic [W-1:0] w, input logic manch);
		step(1);
		if (manch) begin
			rx_line = 1'b0;
			step(HALF_C);
			rx_line = 1'b1; // preamble cell carries a one
			for (int i = 0; i < W; i++) begin
				step(HALF_C);
				rx_line = !w[i];
				step(HALF_C);
				rx_line = w[i];
			end
			step(HALF_C);
			rx_line = 1'b0;
		end else begin
			for (int i = 0; i < W; i++) begin
				rx_line = !rx_line;
				step(HALF_C);
				if (w[i])
					rx_line = !rx_line;
				step(CELL_C - HALF_C);
			end
			rx_line = !rx_line; // closing boundary delivers the last bit
			step(CELL_C);
		end
		step(3 * CELL_C);
	endtask : send

	////////////////////////////////////////////////////////////////////////////////
	// decoder: locks on the first line edge, then samples at fixed offsets in each cell
	task automatic recv(input logic manch, input int n);
		logic l0;
		logic a;
		logic pb;
		int k;
		l0 = tx_line;
		k = 0;
		while (tx_line === l0 && k < 40 * CELL_C) begin
			k++;
			@(negedge clock);
		end
		if (k >= 40 * CELL_C)
			bad++;
		else if (manch) begin
			repeat (2) @(negedge clock);
			for (int i = 0; i < W; i++) begin
				repeat (CELL_C - 4) @(negedge clock);
				a = tx_line;
				repeat (4) @(negedge clock);
				pb = tx_line;
				if (a === pb)
					bad++;
				got[0][i] = pb;
			end
			repeat (CELL_C) @(negedge clock);
			if (tx_line !== 1'b0)
				bad++;
		end else begin
			for (int i = 0; i <= n * W; i++) begin
				repeat (2) @(negedge clock);
				a = tx_line;
				if (i > 0 && a === pb)
					bad++;
				if (i == n * W)
					break;
				repeat (HALF_C) @(negedge clock);
				pb = tx_line;
				got[i / W][i % W] = a ^ pb;
				repeat (CELL_C - HALF_C - 2) @(negedge clock);
			end
		end
	endtask : recv
endmodule : dph_far_end

// ---- testbench.sv ----
/*
 * Self-checking bench for the diphase codec, with shortened cell and pulse counts.
 * Assumes dph_far_end on the line side; inputs change 1 ns after rising edges.
 */
`timescale 1ns/10ps
module testbench;
	import dph_pkg::*;
	localparam int CELL = 8;
	localparam int REC = 6;
	localparam int IDLE = 16;
	logic clock, nrst, clear, manchester_mode, tx_valid, tx_ready, tx_line, rx_line;
	logic [WORD_BITS-1:0] tx_word, rx_word;
	logic rx_word_valid, rx_clock, rx_data_pulse, dp_prev;
	logic [WORD_BITS-1:0] pats [5] = '{10'h2b5, 10'h000, 10'h3ff, 10'h155, 10'h201};
	int miscompares, total_checks, cycles, clk_hi, clk_w, dp_rises;

	dph_codec #(.CELL_C(CELL), .REC_C(REC), .IDLE_C(IDLE)) dut (.clock(clock), .nrst(nrst),
		.clear(clear), .manchester_mode(manchester_mode), .tx_word(tx_word), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_line(tx_line), .rx_line(rx_line), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .rx_clock(rx_clock), .rx_data_pulse(rx_data_pulse));
	dph_far_end #(.CELL_C(CELL), .W(WORD_BITS)) far (.clock(clock), .tx_line(tx_line),
		.rx_line(rx_line));

	////////////////////////////////////////////////////////////////////////////////
	// clock, hang guard, pulse width and data pulse monitors
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	always @(negedge clock) begin
		if (rx_clock === 1'b1)
			clk_hi++;
		else if (clk_hi != 0) begin
			clk_w = clk_hi;
			clk_hi = 0;
		end
		if (rx_data_pulse === 1'b1 && dp_prev !== 1'b1)
			dp_rises++;
		dp_prev = rx_data_pulse;
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : idle

	task automatic push(input logic [WORD_BITS-1:0] w);
		int n;
		n = 0;
		tx_word = w;
		tx_valid = 1'b1;
		@(posedge clock);
		while (tx_ready !== 1'b1 && n < 100) begin
			n++;
			@(posedge clock);
		end
		if (n >= 100)
			miscompares++;
		#1 tx_valid = 1'b0;
	endtask : push

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_tx(input logic [WORD_BITS-1:0] w, input logic manch);
		manchester_mode = manch;
		fork
			far.recv(manch, 1);
			push(w);
		join
		check(far.got[0], w);
		check(far.bad, 0);
		idle(4 * CELL);
	endtask : t_tx

	task automatic t_fill();
		int acc;
		acc = 0;
		fork
			far.recv(1'b0, 5);
			begin
				tx_word = pats[0];
				tx_valid = 1'b1;
				while (acc < 10) begin
					@(posedge clock);
					if (tx_ready !== 1'b1)
						break;
					acc++;
					#1 tx_word = pats[acc % 5];
				end
				#1 tx_valid = 1'b0;
			end
		join
		check(acc, FIFO_DEPTH + 1);
		for (int i = 0; i < 5; i++)
			check(far.got[i], pats[i]);
		check(far.bad, 0);
		idle(4 * CELL);
	endtask : t_fill

	task automatic t_rx(input logic [WORD_BITS-1:0] w, input logic manch);
		int n;
		manchester_mode = manch;
		dp_rises = 0;
		n = 0;
		fork
			far.send(w, manch);
			while (rx_word_valid !== 1'b1 && n < 400) begin
				n++;
				@(negedge clock);
			end
		join
		if (n >= 400)
			miscompares++;
		check(rx_word, w);
		if (!manch) begin
			check(dp_rises, $countones(w));
			check(clk_w, REC);
		end
		idle(2 * IDLE);
	endtask : t_rx

	task automatic t_clear();
		fork
			far.send(10'h3ff, 1'b0);
			begin
				push(pats[3]);
				idle(3 * CELL);
				clear = 1'b1;
				idle(1);
				clear = 1'b0;
				@(negedge clock);
				check({tx_line, tx_ready, rx_clock, rx_data_pulse}, 4'b0100);
				check(rx_word, 0);
				repeat (2 * CELL) @(negedge clock);
				check(tx_line, 1'b0);
			end
		join
		idle(2 * IDLE);
	endtask : t_clear

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		nrst = 1'b0;
		clear = 1'b0;
		manchester_mode = 1'b0;
		tx_valid = 1'b0;
		tx_word = '0;
		miscompares = 0;
		total_checks = 0;
		cycles = 0;
		clk_hi = 0;
		clk_w = 0;
		dp_rises = 0;
		repeat (6) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (2) @(negedge clock);
		check({tx_line, tx_ready, rx_word_valid, rx_clock, rx_data_pulse}, 5'b01000);
		check(rx_word, 0);
		idle(2);
		t_tx(10'h2b5, 1'b1);
		t_rx(10'h2b5, 1'b1);
		for (int i = 0; i < 3; i++)
			t_tx(pats[i], 1'b0);
		t_fill();
		t_rx(10'h2b5, 1'b0);
		t_rx(10'h3ff, 1'b0);
		t_clear();
		t_rx(10'h155, 1'b0);
		wrap_up();
	end
endmodule : testbench
